/* File: core/ssp_serial_ports.sv */
// two rs485 slave ports: framing, addressing, reply delay, receive timeout
`default_nettype none
//
// Operation
// - two ports, each with own configuration
// - own station address must be 1..254
// - accept station zero and own address
// - run-transition start waits for stop-to-run
// - power-up start communicates right after reset
// - standard rate list, 9600 default
// - custom rate 1..5000 in 0.1 kbps
// - configurable framing, default 7E1 ASCII
// - reply delay 0..3000 ms before answer
// - receive timeout 0..3000 ms, default 200
// - port one indicator: line or card one
// - port two indicator: line or card two
module ssp_serial_ports
  import ssp_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // controller state
  input wire logic run_i,
  // per-port configuration
  input wire logic [N_PORTS-1:0][7:0] station_addr_i,
  input wire logic [N_PORTS-1:0] start_on_power_i,
  input wire logic [N_PORTS-1:0][2:0] baud_sel_i,
  input wire logic [N_PORTS-1:0] baud_custom_en_i,
  input wire logic [N_PORTS-1:0][12:0] baud_custom_i,
  input wire logic [N_PORTS-1:0] data_bits8_i,
  input wire logic [N_PORTS-1:0][1:0] parity_i,
  input wire logic [N_PORTS-1:0] stop_bits2_i,
  input wire logic [N_PORTS-1:0] proto_binary_i,
  input wire logic [N_PORTS-1:0][11:0] reply_dly_ms_i,
  input wire logic [N_PORTS-1:0][11:0] rx_tmo_ms_i,
  input wire logic [N_PORTS-1:0] led_card_sel_i,
  // expansion card status
  input wire logic expansion_card_one_stat_i,
  input wire logic expansion_card_two_stat_i,
  // rs485 line
  input wire logic [N_PORTS-1:0] rxd_i,
  output logic [N_PORTS-1:0] txd_o,
  output logic [N_PORTS-1:0] tx_oe_n_o,
  // received request body
  output logic [N_PORTS-1:0][7:0] rx_data_o,
  output logic [N_PORTS-1:0] rx_last_o,
  output logic [N_PORTS-1:0] rx_bcast_o,
  output logic [N_PORTS-1:0] rx_valid_o,
  input wire logic [N_PORTS-1:0] rx_ready_i,
  // reply bytes
  input wire logic [N_PORTS-1:0][7:0] tx_data_i,
  input wire logic [N_PORTS-1:0] tx_last_i,
  input wire logic [N_PORTS-1:0] tx_valid_i,
  output logic [N_PORTS-1:0] tx_ready_o,
  // status
  output logic [N_PORTS-1:0] active_o,
  output logic [N_PORTS-1:0] cfg_err_o,
  output logic [N_PORTS-1:0] rx_err_o,
  output logic [N_PORTS-1:0] rx_tmo_o,
  output logic [N_PORTS-1:0] rx_ovf_o,
  output logic [N_PORTS-1:0] led_o
);
  localparam int MSW = $clog2(MS_CYC + 1);
  logic [MSW-1:0] ms_cnt_reg, ms_cnt_next;
  logic ms_tick;
  logic run_d_reg, run_d_next;

  // shared millisecond base; first tick of a wait may be partial
  always_comb begin
    ms_tick = (ms_cnt_reg == MSW'(MS_CYC - 1));
    ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + 1'b1;
    run_d_next = run_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ms_cnt_reg <= '0;
      run_d_reg <= 1'b0;
    end else begin
      ms_cnt_reg <= ms_cnt_next;
      run_d_reg <= run_d_next;
    end
  end

  for (genvar c = 0; c < N_PORTS; c++) begin : g_port
    logic act_reg, act_next, cerr_reg, cerr_next, led_reg, led_next;
    logic [23:0] acc_reg, acc_next;
    logic [1:0] sync_reg, sync_next;
    logic [19:0] rate;
    logic tick16, rx_in, card_stat;
    logic [2:0] last_bit;

    assign card_stat = (c == 0) ? expansion_card_one_stat_i : expansion_card_two_stat_i;
    assign rx_in = sync_reg[1];
    assign last_bit = data_bits8_i[c] ? LAST_BIT8 : LAST_BIT7;

    // receive machine state
    ssp_uart_st_t rs_reg, rs_next;
    logic [3:0] rc_reg, rc_next;
    logic [2:0] rb_reg, rb_next;
    logic [7:0] rsh_reg, rsh_next, rbyte;
    logic rdone_reg, rdone_next, rerr_reg, rerr_next, rpe_reg, rpe_next;
    // frame state
    ssp_frame_st_t fs_reg, fs_next;
    logic [3:0] hi_reg, hi_next;
    logic hn_reg, hn_next, bc_reg, bc_next, pv_reg, pv_next;
    logic [7:0] pend_reg, pend_next, own;
    logic fl_reg, fl_next, ftmo_reg, ftmo_next, tmo_reg, tmo_next, ovf_reg, ovf_next;
    logic [9:0] gap_reg, gap_next;
    logic [11:0] tms_reg, tms_next;
    logic wr_v, wr_rdy, hit, arm;
    logic [FIFO_W-1:0] wr_d;
    // reply and transmit state
    ssp_reply_st_t ps_reg, ps_next;
    logic [11:0] dms_reg, dms_next;
    logic tx_rdy, send;
    ssp_uart_st_t ts_reg, ts_next;
    logic [3:0] tc_reg, tc_next;
    logic [2:0] tb_reg, tb_next;
    logic [7:0] tsh_reg, tsh_next;
    logic tpar_reg, tpar_next, txd_reg, txd_next, oen_reg, oen_next;

    // enable, configuration check, bit clock, line sync, indicator
    always_comb begin
      act_next = act_reg;
      if (start_on_power_i[c]) act_next = 1'b1;
      else if (run_i && !run_d_reg) act_next = 1'b1;
      else if (!run_i) act_next = 1'b0;
      cerr_next = (station_addr_i[c] == ADDR_BCAST) || (station_addr_i[c] > ADDR_MAX) ||
        (baud_custom_en_i[c] && (baud_custom_i[c] < CUST_MIN || baud_custom_i[c] > CUST_MAX));
      if (baud_custom_en_i[c]) rate = 20'(baud_custom_i[c]) * CUST_UNIT_BPS;
      else rate = ssp_std_rate(baud_sel_i[c]);
      // fractional accumulator avoids a divider for arbitrary rates
      acc_next = acc_reg + 24'(rate);
      tick16 = (acc_next >= OVS_MOD);
      if (tick16) acc_next = acc_next - OVS_MOD;
      sync_next = {sync_reg[0], rxd_i[c]};
      led_next = led_card_sel_i[c] ? card_stat : (rs_reg != U_IDLE || ts_reg != U_IDLE);
    end

    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
        act_reg <= 1'b0;
        cerr_reg <= 1'b0;
        acc_reg <= '0;
        sync_reg <= 2'h3;
        led_reg <= 1'b0;
      end else begin
        act_reg <= act_next;
        cerr_reg <= cerr_next;
        acc_reg <= acc_next;
        sync_reg <= sync_next;
        led_reg <= led_next;
      end
    end

    // character receiver, 16x oversampled
    always_comb begin
      rs_next = rs_reg;
      rc_next = rc_reg;
      rb_next = rb_reg;
      rsh_next = rsh_reg;
      rpe_next = rpe_reg;
      rdone_next = 1'b0;
      rerr_next = 1'b0;
      if (rs_reg == U_IDLE) begin
        rc_next = '0;
        if (!rx_in) rs_next = U_START;
      end else if (tick16) begin
        rc_next = rc_reg + 4'h1;
        case (rs_reg)
          U_START: if (rc_reg == MID_SAMPLE) begin
            rc_next = '0;
            rb_next = '0;
            rsh_next = '0;
            rpe_next = 1'b0;
            rs_next = rx_in ? U_IDLE : U_DATA;
          end
          U_DATA: if (rc_reg == LAST_SAMPLE) begin
            rsh_next = {rx_in, rsh_reg[7:1]};
            rb_next = rb_reg + 3'h1;
            if (rb_reg == last_bit) rs_next = (parity_i[c] == PAR_NONE) ? U_STOP : U_PAR;
          end
          U_PAR: if (rc_reg == LAST_SAMPLE) begin
            // unused low bit is zero, so it leaves the xor alone
            rpe_next = ^rsh_reg ^ rx_in ^ (parity_i[c] == PAR_ODD);
            rs_next = U_STOP;
          end
          U_STOP: if (rc_reg == LAST_SAMPLE) begin
            rs_next = U_IDLE;
            rdone_next = rx_in && !rpe_reg;
            rerr_next = !rx_in || rpe_reg;
          end
          default: rs_next = U_IDLE;
        endcase
      end
    end

    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
        rs_reg <= U_IDLE;
        rc_reg <= '0;
        rb_reg <= '0;
        rsh_reg <= '0;
        rpe_reg <= 1'b0;
        rdone_reg <= 1'b0;
        rerr_reg <= 1'b0;
      end else begin
        rs_reg <= rs_next;
        rc_reg <= rc_next;
        rb_reg <= rb_next;
        rsh_reg <= rsh_next;
        rpe_reg <= rpe_next;
        rdone_reg <= rdone_next;
        rerr_reg <= rerr_next;
      end
    end

    // framing, address filter, body into the fifo one byte late so the end can be marked
    always_comb begin
      fs_next = fs_reg;
      hi_next = hi_reg;
      hn_next = hn_reg;
      bc_next = bc_reg;
      pend_next = pend_reg;
      pv_next = pv_reg;
      gap_next = gap_reg;
      tms_next = tms_reg;
      fl_next = 1'b0;
      ftmo_next = 1'b0;
      tmo_next = 1'b0;
      arm = 1'b0;
      wr_v = 1'b0;
      wr_d = {bc_reg, 1'b0, pend_reg};
      rbyte = data_bits8_i[c] ? rsh_reg : {1'b0, rsh_reg[7:1]};
      own = proto_binary_i[c] ? rbyte : {hi_reg, ssp_hex(rbyte)};
      hit = (own == ADDR_BCAST) || (own == station_addr_i[c] && !cerr_reg);
      if (fl_reg) begin
        wr_v = pv_reg;
        wr_d = {bc_reg, 1'b1, pend_reg};
        pv_next = 1'b0;
        arm = !ftmo_reg;
      end
      if (rdone_reg) begin
        gap_next = '0;
        tms_next = '0;
        case (fs_reg)
          F_IDLE: if (proto_binary_i[c]) begin
            bc_next = (own == ADDR_BCAST);
            fs_next = hit ? F_BODY : F_SKIP;
          end else if (rbyte == ASCII_SOF) begin
            hn_next = 1'b0;
            fs_next = F_ADDR;
          end
          F_ADDR: if (!hn_reg) begin
            hi_next = ssp_hex(rbyte);
            hn_next = 1'b1;
          end else begin
            bc_next = (own == ADDR_BCAST);
            fs_next = hit ? F_BODY : F_SKIP;
          end
          F_BODY: begin
            wr_v = pv_reg;
            pend_next = rbyte;
            pv_next = 1'b1;
            if (!proto_binary_i[c] && rbyte == ASCII_EOF) begin
              fs_next = F_IDLE;
              fl_next = 1'b1;
            end
          end
          F_SKIP: if (!proto_binary_i[c] && rbyte == ASCII_EOF) fs_next = F_IDLE;
          default: fs_next = F_IDLE;
        endcase
      end else if (fs_reg != F_IDLE) begin
        if (tick16 && gap_reg != GAP_TICKS) gap_next = gap_reg + 10'h1;
        if (ms_tick) tms_next = tms_reg + 12'h1;
        if (rx_tmo_ms_i[c] != '0 && tms_reg >= rx_tmo_ms_i[c]) begin
          fs_next = F_IDLE;
          fl_next = (fs_reg == F_BODY);
          ftmo_next = 1'b1;
          tmo_next = 1'b1;
        end else if (proto_binary_i[c] && gap_reg == GAP_TICKS) begin
          fs_next = F_IDLE;
          fl_next = (fs_reg == F_BODY);
        end
      end
      if (!act_reg) fs_next = F_IDLE;
      // receive fifo cannot stall the line, so a full fifo loses the byte
      ovf_next = wr_v && !wr_rdy;
    end

    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
        fs_reg <= F_IDLE;
        hi_reg <= '0;
        hn_reg <= 1'b0;
        bc_reg <= 1'b0;
        pend_reg <= '0;
        pv_reg <= 1'b0;
        gap_reg <= '0;
        tms_reg <= '0;
        fl_reg <= 1'b0;
        ftmo_reg <= 1'b0;
        tmo_reg <= 1'b0;
        ovf_reg <= 1'b0;
      end else begin
        fs_reg <= fs_next;
        hi_reg <= hi_next;
        hn_reg <= hn_next;
        bc_reg <= bc_next;
        pend_reg <= pend_next;
        pv_reg <= pv_next;
        gap_reg <= gap_next;
        tms_reg <= tms_next;
        fl_reg <= fl_next;
        ftmo_reg <= ftmo_next;
        tmo_reg <= tmo_next;
        ovf_reg <= ovf_next;
      end
    end

    ssp_fifo_if #(.W(FIFO_W)) fq ();
    assign fq.wr_valid = wr_v;
    assign fq.wr_data = wr_d;
    assign wr_rdy = fq.wr_ready;
    assign fq.rd_ready = rx_ready_i[c];
    ssp_fifo #(.W(FIFO_W), .DEPTH(DEPTH)) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .q(fq)
    );

    // reply sequencing; a new request aborts an unfinished reply
    always_comb begin
      ps_next = ps_reg;
      dms_next = dms_reg;
      tx_rdy = 1'b0;
      send = 1'b0;
      case (ps_reg)
        R_IDLE: ps_next = R_IDLE;
        R_DELAY: begin
          if (ms_tick) dms_next = dms_reg + 12'h1;
          if (dms_reg >= reply_dly_ms_i[c]) ps_next = R_SEND;
        end
        R_SEND: begin
          tx_rdy = (ts_reg == U_IDLE);
          send = tx_valid_i[c] && tx_rdy;
          if (send && tx_last_i[c]) ps_next = R_IDLE;
        end
        R_DROP: begin
          tx_rdy = 1'b1;
          if (tx_valid_i[c] && tx_last_i[c]) ps_next = R_IDLE;
        end
        default: ps_next = R_IDLE;
      endcase
      if (arm) begin
        dms_next = '0;
        ps_next = bc_reg ? R_DROP : R_DELAY;
      end
      if (!act_reg) ps_next = R_IDLE;
    end

    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
        ps_reg <= R_IDLE;
        dms_reg <= '0;
      end else begin
        ps_reg <= ps_next;
        dms_reg <= dms_next;
      end
    end

    // character transmitter
    always_comb begin
      ts_next = ts_reg;
      tc_next = tc_reg;
      tb_next = tb_reg;
      tsh_next = tsh_reg;
      tpar_next = tpar_reg;
      txd_next = txd_reg;
      if (ts_reg == U_IDLE) begin
        tc_next = '0;
        txd_next = 1'b1;
        if (send) begin
          ts_next = U_START;
          txd_next = 1'b0;
          tsh_next = tx_data_i[c];
          tb_next = '0;
          tpar_next = (parity_i[c] == PAR_ODD);
        end
      end else if (tick16) begin
        tc_next = tc_reg + 4'h1;
        if (tc_reg == LAST_SAMPLE) begin
          case (ts_reg)
            U_START: begin
              ts_next = U_DATA;
              txd_next = tsh_reg[0];
              tpar_next = tpar_reg ^ tsh_reg[0];
              tsh_next = tsh_reg >> 1;
            end
            U_DATA: if (tb_reg == last_bit) begin
              ts_next = (parity_i[c] == PAR_NONE) ? U_STOP : U_PAR;
              txd_next = (parity_i[c] == PAR_NONE) ? 1'b1 : tpar_reg;
              tb_next = '0;
            end else begin
              tb_next = tb_reg + 3'h1;
              txd_next = tsh_reg[0];
              tpar_next = tpar_reg ^ tsh_reg[0];
              tsh_next = tsh_reg >> 1;
            end
            U_PAR: begin
              ts_next = U_STOP;
              txd_next = 1'b1;
            end
            U_STOP: begin
              tb_next = tb_reg + 3'h1;
              if (tb_reg == {2'b00, stop_bits2_i[c]}) ts_next = U_IDLE;
            end
            default: ts_next = U_IDLE;
          endcase
        end
      end
      oen_next = (ts_next == U_IDLE);
    end

    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
        ts_reg <= U_IDLE;
        tc_reg <= '0;
        tb_reg <= '0;
        tsh_reg <= '0;
        tpar_reg <= 1'b0;
        txd_reg <= 1'b1;
        oen_reg <= 1'b1;
      end else begin
        ts_reg <= ts_next;
        tc_reg <= tc_next;
        tb_reg <= tb_next;
        tsh_reg <= tsh_next;
        tpar_reg <= tpar_next;
        txd_reg <= txd_next;
        oen_reg <= oen_next;
      end
    end

    assign txd_o[c] = txd_reg;
    assign tx_oe_n_o[c] = oen_reg;
    assign rx_valid_o[c] = fq.rd_valid;
    assign rx_bcast_o[c] = fq.rd_data[9];
    assign rx_last_o[c] = fq.rd_data[8];
    assign rx_data_o[c] = fq.rd_data[7:0];
    assign tx_ready_o[c] = tx_rdy;
    assign active_o[c] = act_reg;
    assign cfg_err_o[c] = cerr_reg;
    assign rx_err_o[c] = rerr_reg;
    assign rx_tmo_o[c] = tmo_reg;
    assign rx_ovf_o[c] = ovf_reg;
    assign led_o[c] = led_reg;
  end
endmodule : ssp_serial_ports
`default_nettype wire

/* File: core/ssp_pkg.sv */
// shared constants, types and helpers of the serial slave ports
`default_nettype none
package ssp_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int OVS = 16;
  localparam logic [23:0] OVS_MOD = 24'(CLK_HZ / OVS);
  localparam int N_PORTS = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 10;
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX = 8'hfe;
  localparam logic [7:0] ADDR_DEF = 8'h01;
  localparam logic [2:0] BAUD_SEL_DEF = 3'h3;
  localparam logic [19:0] CUST_UNIT_BPS = 20'h00064;
  localparam logic [12:0] CUST_MIN = 13'h0001;
  localparam logic [12:0] CUST_MAX = 13'h1388;
  localparam logic [12:0] CUST_DEF = 13'h0060;
  localparam logic DATA8_DEF = 1'b0;
  localparam logic STOP2_DEF = 1'b0;
  localparam logic BINARY_DEF = 1'b0;
  localparam logic [11:0] DLY_DEF_MS = 12'h000;
  localparam logic [11:0] DLY_MAX_MS = 12'hbb8;
  localparam logic [11:0] TMO_DEF_MS = 12'h0c8;
  localparam logic [11:0] TMO_MAX_MS = 12'hbb8;
  localparam logic [7:0] ASCII_SOF = 8'h3a;
  localparam logic [7:0] ASCII_EOF = 8'h0a;
  localparam logic [9:0] GAP_TICKS = 10'h280;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  localparam logic [3:0] LAST_SAMPLE = 4'hf;
  localparam logic [2:0] LAST_BIT8 = 3'h7;
  localparam logic [2:0] LAST_BIT7 = 3'h6;

  typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_EVEN = 2'b01, PAR_ODD = 2'b10} ssp_parity_t;
  localparam ssp_parity_t PARITY_DEF = PAR_EVEN;
  typedef enum logic [2:0] {
    U_IDLE = 3'b000, U_START = 3'b001, U_DATA = 3'b010, U_PAR = 3'b011, U_STOP = 3'b100
  } ssp_uart_st_t;
  typedef enum logic [1:0] {F_IDLE = 2'b00, F_ADDR = 2'b01, F_BODY = 2'b10, F_SKIP = 2'b11} ssp_frame_st_t;
  typedef enum logic [1:0] {R_IDLE = 2'b00, R_DELAY = 2'b01, R_SEND = 2'b10, R_DROP = 2'b11} ssp_reply_st_t;

  function automatic logic [19:0] ssp_std_rate(input logic [2:0] sel);
    case (sel)
      3'h0: return 20'h004b0;
      3'h1: return 20'h00960;
      3'h2: return 20'h012c0;
      3'h3: return 20'h02580;
      3'h4: return 20'h04b00;
      3'h5: return 20'h09600;
      3'h6: return 20'h0e100;
      default: return 20'h1c200;
    endcase
  endfunction : ssp_std_rate

  // letters map by their low nibble, so either case works
  function automatic logic [3:0] ssp_hex(input logic [7:0] ch);
    logic [7:0] v;
    v = (ch >= 8'h41) ? ch - 8'h37 : ch - 8'h30;
    return v[3:0];
  endfunction : ssp_hex
endpackage : ssp_pkg
`default_nettype wire

/* File: core/ssp_fifo_if.sv */
// handshake bundle between a port and its receive fifo
`default_nettype none
interface ssp_fifo_if #(parameter int W = 8);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport fifo (input wr_valid, input wr_data, input rd_ready, output wr_ready, output rd_valid, output rd_data);
  modport src (output wr_valid, output wr_data, input wr_ready);
  modport snk (input rd_valid, input rd_data, output rd_ready);
endinterface : ssp_fifo_if
`default_nettype wire

/* File: core/ssp_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`default_nettype none
module ssp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // fill and drain sides
  ssp_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [W-1:0] mem_next [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  always_comb begin
    q.wr_ready = (cnt_reg != (AW+1)'(DEPTH));
    q.rd_valid = (cnt_reg != '0);
    q.rd_data = mem_reg[rp_reg];
    push = q.wr_valid && q.wr_ready;
    pop = q.rd_valid && q.rd_ready;
    mem_next = mem_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (push) begin
      mem_next[wp_reg] = q.wr_data;
      wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
    end
    if (pop) begin
      rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
    end
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mem_reg <= '{default: '0};
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : ssp_fifo
`default_nettype wire

/* File: verification/ssp_master_model.sv */
// remote master station driving the shared rs485 line
`default_nettype none
module ssp_master_model #(
  parameter int BIT_CYC = 200
) (
  // clock
  input wire logic clk_i,
  // line towards both slaves, idles high
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line_o = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] sh;
    sh = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      line_o <= sh[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask : send
  task automatic frame(input logic [7:0] addr);
    send(addr);
    send(8'ha5);
    send(8'h3c);
    // silence longer than the end-of-frame gap
    repeat (9000) @(posedge clk_i);
  endtask : frame
endmodule : ssp_master_model
`default_nettype wire

/* File: verification/ssp_monitor.sv */
// port-level checker of the two serial slave ports
`default_nettype none
module ssp_monitor
  import ssp_pkg::*;
(
  // clock, reset and controller
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  // configuration
  input wire logic [N_PORTS-1:0][7:0] station_addr_i,
  input wire logic [N_PORTS-1:0] start_on_power_i,
  input wire logic [N_PORTS-1:0] led_card_sel_i,
  input wire logic expansion_card_one_stat_i,
  input wire logic expansion_card_two_stat_i,
  // outputs watched
  input wire logic [N_PORTS-1:0] txd_o,
  input wire logic [N_PORTS-1:0] tx_oe_n_o,
  input wire logic [N_PORTS-1:0] tx_ready_o,
  input wire logic [N_PORTS-1:0] active_o,
  input wire logic [N_PORTS-1:0] cfg_err_o,
  input wire logic [N_PORTS-1:0] led_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_pwr; $rose(rst_n_i) && start_on_power_i[0] |-> ##[0:2] active_o[0]; endproperty
  a_pwr: assert property (p_pwr) else $error("power-up start late");
  property p_run_off; (!start_on_power_i[1] && !run_i) [*2] |-> !active_o[1]; endproperty
  a_run_off: assert property (p_run_off) else $error("port active while stopped");
  property p_run_on; $rose(run_i) && !start_on_power_i[1] |-> ##[1:2] active_o[1]; endproperty
  a_run_on: assert property (p_run_on) else $error("run start late");
  property p_cfg; (station_addr_i[1] == ADDR_BCAST) [*2] |-> cfg_err_o[1]; endproperty
  a_cfg: assert property (p_cfg) else $error("zero address not flagged");
  property p_led1; led_card_sel_i[0] |=> led_o[0] == $past(expansion_card_one_stat_i); endproperty
  a_led1: assert property (p_led1) else $error("indicator one wrong");
  property p_led2; led_card_sel_i[1] |=> led_o[1] == $past(expansion_card_two_stat_i); endproperty
  a_led2: assert property (p_led2) else $error("indicator two wrong");
  property p_start; $fell(tx_oe_n_o[0]) |-> !txd_o[0] [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit missing");
  property p_busy; !tx_oe_n_o[0] |-> !tx_ready_o[0]; endproperty
  a_busy: assert property (p_busy) else $error("ready while sending");
  c_run: cover property ($rose(active_o[1]));
  c_tx: cover property ($fell(tx_oe_n_o[0]));
  c_cfg: cover property ($rose(cfg_err_o[1]));
endmodule : ssp_monitor
bind ssp_serial_ports ssp_monitor u_mon (.clk_sys_i, .rst_n_i, .run_i, .station_addr_i, .start_on_power_i,
  .led_card_sel_i, .expansion_card_one_stat_i, .expansion_card_two_stat_i, .txd_o, .tx_oe_n_o, .tx_ready_o,
  .active_o, .cfg_err_o, .led_o);
`default_nettype wire

/* File: verification/ssp_serial_ports_tb.sv */
// self-checking bench of the two serial slave ports
`default_nettype none
module ssp_serial_ports_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, run, c1, c2, line;
  logic [1:0][7:0] sa, td, rd;
  logic [1:0][11:0] dl, to;
  logic [1:0][1:0] pa;
  logic [1:0][2:0] bs;
  logic [1:0][12:0] cu;
  logic [1:0] ce, d8, s2, sp, pb, ls, rr, tl, tv, txd, oe, rl, rb, rv, trdy, act, cerr, tmo, led;
  logic [7:0] av [4] = '{8'h00, 8'hff, 8'hfe, 8'h02};
  int miscompares, comparisons, n;
  always #5 clk = ~clk;
  ssp_master_model u_mst (.clk_i(clk), .line_o(line));
  // fastest custom rate keeps frames short: 200 cycles a bit
  ssp_serial_ports #(.MS_CYC(100)) u_dut (.clk_sys_i(clk), .rst_n_i(rst_n), .run_i(run),
    .station_addr_i(sa), .start_on_power_i(sp), .baud_sel_i(bs), .baud_custom_en_i(ce),
    .baud_custom_i(cu), .data_bits8_i(d8), .parity_i(pa), .stop_bits2_i(s2),
    .proto_binary_i(pb), .reply_dly_ms_i(dl), .rx_tmo_ms_i(to), .led_card_sel_i(ls),
    .expansion_card_one_stat_i(c1), .expansion_card_two_stat_i(c2), .rxd_i({2{line}}), .txd_o(txd),
    .tx_oe_n_o(oe), .rx_data_o(rd), .rx_last_o(rl), .rx_bcast_o(rb), .rx_valid_o(rv), .rx_ready_i(rr),
    .tx_data_i(td), .tx_last_i(tl), .tx_valid_i(tv), .tx_ready_o(trdy), .active_o(act), .cfg_err_o(cerr),
    .rx_err_o(), .rx_tmo_o(tmo), .rx_ovf_o(), .led_o(led));
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk
  // word layout: bcast, last, data
  task automatic pop(input int c, input logic [9:0] exp);
    @(negedge clk);
    repeat (100) if (rv[c] !== 1'b1) @(negedge clk);
    chk("rx word", exp, {rb[c], rl[c], rd[c]});
    @(posedge clk) rr[c] <= 1'b1;
    @(posedge clk) rr[c] <= 1'b0;
  endtask : pop
  task automatic reply(input int c);
    @(posedge clk);
    td[c] <= 8'h55;
    tl[c] <= 1'b1;
    tv[c] <= 1'b1;
    @(negedge clk);
    repeat (1000) if (trdy[c] !== 1'b1) @(negedge clk);
    @(posedge clk);
    tv[c] <= 1'b0;
  endtask : reply
  task automatic t_start();
    repeat (3) @(negedge clk);
    chk("active", 10'h001, 10'(act));
    @(posedge clk) run <= 1'b1;
    repeat (3) @(negedge clk);
    chk("active", 10'h003, 10'(act));
  endtask : t_start
  task automatic t_own();
    // end-of-frame gap plus delay outlast the silence after the frame, so ready must still be low
    @(posedge clk) dl[0] <= 12'd15;
    u_mst.frame(8'h01);
    chk("early ready", 10'h000, 10'(trdy));
    chk("rx valid", 10'h001, 10'(rv));
    pop(0, 10'h0a5);
    pop(0, 10'h13c);
    reply(0);
    repeat (2) @(negedge clk);
    chk("start bit", 10'h000, 10'({oe[0], txd[0]}));
    repeat (100) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (200) @(negedge clk);
      chk("tx bit", 10'((8'h55 >> i) & 8'h01), 10'(txd[0]));
    end
    repeat (400) @(negedge clk);
    chk("tx done", 10'h001, 10'(oe[0]));
  endtask : t_own
  task automatic t_bcast();
    u_mst.frame(8'h00);
    pop(0, 10'h2a5);
    pop(0, 10'h33c);
    pop(1, 10'h2a5);
    pop(1, 10'h33c);
    reply(0);
    n = 0;
    repeat (3000) begin
      @(negedge clk);
      if (oe[0] !== 1'b1) n++;
    end
    chk("bcast silent", 10'h000, 10'(n));
  endtask : t_bcast
  task automatic t_other();
    u_mst.frame(8'h03);
    chk("foreign frame", 10'h000, 10'(rv));
  endtask : t_other
  task automatic t_cfg();
    foreach (av[i]) begin
      @(posedge clk) sa[1] <= av[i];
      repeat (3) @(negedge clk);
      chk("cfg err", 10'(av[i] == 8'h00 || av[i] == 8'hff), 10'(cerr[1]));
    end
    @(posedge clk) cu[1] <= 13'd5001;
    repeat (3) @(negedge clk);
    chk("cfg rate", 10'h001, 10'(cerr[1]));
    // standard table selected: custom value no longer matters
    @(posedge clk) ce[1] <= 1'b0;
    repeat (3) @(negedge clk);
    chk("cfg rate", 10'h000, 10'(cerr[1]));
    @(posedge clk) {ce[1], cu[1]} <= {1'b1, 13'd5000};
  endtask : t_cfg
  task automatic t_led();
    @(posedge clk);
    ls <= 2'b11;
    c1 <= 1'b1;
    repeat (3) @(negedge clk);
    chk("led", 10'h001, 10'(led));
    @(posedge clk);
    c1 <= 1'b0;
    c2 <= 1'b1;
    repeat (3) @(negedge clk);
    chk("led", 10'h002, 10'(led));
  endtask : t_led
  // ascii frame left open: only the timeout can close it
  task automatic t_tmo();
    @(posedge clk);
    pb[0] <= 1'b0;
    to[0] <= 12'd30;
    u_mst.send(8'h3a);
    u_mst.send(8'h30);
    u_mst.send(8'h31);
    u_mst.send(8'h41);
    n = 0;
    repeat (4000) begin
      @(negedge clk);
      if (tmo[0] === 1'b1) n++;
    end
    chk("timeout", 10'h001, 10'(n));
    pop(0, 10'h141);
  endtask : t_tmo
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    {clk, rst_n, run, c1, c2, ls, rr, tl, tv, td, pa, dl, bs, s2} = '0;
    {ce, d8} = '1;
    cu = {2{13'd5000}};
    sa = {8'h02, 8'h01};
    sp = 2'b01;
    pb = 2'b11;
    to = {2{12'd200}};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_start();
    t_own();
    t_bcast();
    t_other();
    t_cfg();
    t_led();
    t_tmo();
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule : ssp_serial_ports_tb
`default_nettype wire
